// file: tb_top.sv
// Self-checking testbench for the voltage-restrained overcurrent stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module tb_top;
   localparam int CYC = 200;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic block_in = 1'b0;
   logic load = 1'b0;
   logic [15:0] cur1 = 16'h0, cur2 = 16'h0, cur3 = 16'h0, volt = 16'h0;
   logic [15:0] i_l1, i_l2, i_l3, u_ch1, u_ch2, u_ch3, u_ch4;
   logic [31:0] hrdata;
   logic hreadyout, hresp, start_out, trip_out, blocked_out, irq;
   int mismatches = 0;
   int checked = 0;
   string nq[$];
   logic [31:0] eq[$];
   logic [31:0] seen_v;
   event seen_ev;
   logic [2:0] mexp[5] = '{3'b100, 3'b001, 3'b100, 3'b001, 3'b000};
   logic [2:0] fexp[4] = '{3'b100, 3'b100, 3'b010, 3'b001};
   vro_meas fe (.hclk(hclk), .hresetn(hresetn), .load(load), .cur1(cur1), .cur2(cur2),
      .cur3(cur3), .volt(volt), .i_l1(i_l1), .i_l2(i_l2), .i_l3(i_l3), .u_ch1(u_ch1),
      .u_ch2(u_ch2), .u_ch3(u_ch3), .u_ch4(u_ch4));
   vro_stage #(.CYCLE_CLKS(CYC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .i_l1(i_l1), .i_l2(i_l2), .i_l3(i_l3), .u_ch1(u_ch1), .u_ch2(u_ch2), .u_ch3(u_ch3),
      .u_ch4(u_ch4), .block_in(block_in), .start_out(start_out), .trip_out(trip_out),
      .blocked_out(blocked_out), .irq(irq));
   initial begin
      forever #5 hclk = ~hclk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic note(input string n, input logic [31:0] e);
      nq.push_back(n);
      eq.push_back(e);
   endtask
   task automatic seen(input logic [31:0] g);
      seen_v = g;
      ->seen_ev;
      #1;
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] d);
      @(posedge hclk);
      {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, w};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      xfer(a, 1'b1, v, x);
   endtask
   task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
      logic [31:0] d;
      note(n, e);
      xfer(a, 1'b0, 32'h0, d);
      seen(d);
   endtask
   task automatic pins(input logic [2:0] e);
      note("pins", {29'h0, e});
      seen({29'h0, start_out, trip_out, blocked_out});
   endtask
   task automatic cyc;
      repeat (2 * CYC + 150) @(posedge hclk);
   endtask
   task automatic meas(input logic [15:0] a, input logic [15:0] b, input logic [15:0] u);
      @(posedge hclk);
      {cur1, cur2, cur3, volt, load} <= {a, b, 16'h0, u, 1'b1};
      @(posedge hclk);
      load <= 1'b0;
      cyc();
   endtask
   initial begin
      string n;
      logic [31:0] e;
      forever begin
         @(seen_ev);
         n = nq.pop_front();
         e = eq.pop_front();
         `CHK(n, e, seen_v)
      end
   end
   initial begin
      repeat (40000) @(posedge hclk);
      mismatches++;
      conclude();
   end
   initial begin
      logic [15:0] c;
      logic pk;
      void'($urandom(9718));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(vro_pkg::CTRL_OFS, "ctrl", 32'h0);
      rd(vro_pkg::ILOW_OFS, "ilow", 32'h14);
      rd(vro_pkg::IHIGH_OFS, "ihigh", 32'h78);
      rd(vro_pkg::ULOW_OFS, "ulow", 32'h7D0);
      rd(vro_pkg::UHIGH_OFS, "uhigh", 32'h2710);
      rd(8'h40, "unmapped", 32'h0);
      wr(vro_pkg::IRQ_MASK_OFS, 32'hF);
      meas(16'h0, 16'h0, 16'h1388);
      rd(vro_pkg::U1_OFS, "u1", 32'h1388);
      rd(vro_pkg::PICKUP_OFS, "pickup", 32'h39);
      rd(vro_pkg::STATUS_OFS, "status", 32'h100);
      pk = 1'b0;
      for (int k = 0; k < 7; k++) begin
         c = (k == 0) ? 16'h3A : (k == 1) ? 16'h38 : (k == 2) ? 16'h37 : 16'($urandom_range(40, 80));
         meas(16'h0, c, 16'h1388);
         pk = pk ? (32'(c) * 100 >= 57 * 97) : (c > 16'h39);
         pins({pk, 2'b00});
         rd(vro_pkg::RATIO_OFS + 8'h04, "ratio2", (32'(c) * 100) / 57);
      end
      meas(16'h3A, 16'h0, 16'h3E8);
      rd(vro_pkg::PICKUP_OFS, "pickup", 32'h14);
      pins(3'b100);
      meas(16'h0, 16'h0, 16'h2EE0);
      rd(vro_pkg::PICKUP_OFS, "pickup", 32'h78);
      rd(vro_pkg::IRQ_STAT_OFS, "irq_stat", 32'h3);
      note("irq", 32'h1);
      seen({31'h0, irq});
      note("hresp", 32'h0);
      seen({31'h0, hresp});
      wr(vro_pkg::IRQ_STAT_OFS, 32'h3);
      rd(vro_pkg::IRQ_STAT_OFS, "irq_stat", 32'h0);
      wr(vro_pkg::UHIGH_OFS, 32'h1F40);
      wr(vro_pkg::ULOW_OFS, 32'h1F40);
      meas(16'h32, 16'h0, 16'h2328);
      pins(3'b000);
      meas(16'h32, 16'h0, 16'h1B58);
      pins(3'b100);
      rd(vro_pkg::STATUS_OFS, "status", 32'h11);
      @(posedge hclk);
      block_in <= 1'b1;
      cyc();
      pins(3'b001);
      @(posedge hclk);
      block_in <= 1'b0;
      cyc();
      pins(3'b100);
      rd(vro_pkg::IRQ_STAT_OFS, "irq_stat", 32'hF);
      wr(vro_pkg::CTRL_OFS, 32'h340);
      rd(vro_pkg::CTRL_OFS, "ctrl", 32'h340);
      cyc();
      pins(3'b100);
      for (int m = 0; m < 5; m++) begin
         wr(vro_pkg::CTRL_OFS, 32'h1 | (32'(m) << 4));
         cyc();
         pins(mexp[m]);
      end
      for (int f = 0; f < 4; f++) begin
         wr(vro_pkg::CTRL_OFS, 32'h2 | (32'(f) << 8));
         cyc();
         pins(fexp[f]);
      end
      conclude();
   end
endmodule
`default_nettype wire

// file: vro_div.sv
// Sequential radix-2 divider, 32-bit dividend by 16-bit divisor
`timescale 1ns/1ns
`default_nettype none
module vro_div (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, active low
   input wire logic start, // Start pulse, ignored while busy
   input wire logic [31:0] dividend, // Numerator
   input wire logic [15:0] divisor, // Denominator
   output logic busy, // Division running
   output logic done, // One-cycle pulse, quotient valid
   output logic [31:0] quotient // Result, all ones on divide by zero
);
   logic [5:0] cnt_q;
   logic [31:0] num_q;
   logic [16:0] rem_q;
   logic [15:0] den_q;
   logic [16:0] trial;

   assign trial = {rem_q[15:0], num_q[31]};
   assign busy = (cnt_q != 6'h00);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 6'h00;
         num_q <= 32'h00000000;
         rem_q <= 17'h00000;
         den_q <= 16'h0000;
         done <= 1'b0;
         quotient <= 32'h00000000;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            cnt_q <= 6'h20;
            num_q <= dividend;
            rem_q <= 17'h00000;
            den_q <= divisor;
         end else if (busy) begin
            cnt_q <= cnt_q - 6'h01;
            if (trial >= {1'b0, den_q}) begin
               rem_q <= trial - {1'b0, den_q};
               num_q <= {num_q[30:0], 1'b1};
            end else begin
               rem_q <= trial;
               num_q <= {num_q[30:0], 1'b0};
            end
            if (cnt_q == 6'h01) begin
               done <= 1'b1;
               if (den_q == 16'h0000) begin
                  quotient <= 32'hFFFFFFFF;
               end else begin
                  quotient <= {num_q[30:0], (trial >= {1'b0, den_q})};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: vro_meas.sv
// Measurement front end model feeding phase currents and voltage magnitudes
`timescale 1ns/1ns
`default_nettype none
module vro_meas (
   input wire logic hclk, // Clock
   input wire logic hresetn, // Async reset, active low
   input wire logic load, // Take new magnitudes
   input wire logic [15:0] cur1, // Next phase 1 current
   input wire logic [15:0] cur2, // Next phase 2 current
   input wire logic [15:0] cur3, // Next phase 3 current
   input wire logic [15:0] volt, // Next channel voltage
   output logic [15:0] i_l1, // Phase 1 current
   output logic [15:0] i_l2, // Phase 2 current
   output logic [15:0] i_l3, // Phase 3 current
   output logic [15:0] u_ch1, // Channel 1 voltage
   output logic [15:0] u_ch2, // Channel 2 voltage
   output logic [15:0] u_ch3, // Channel 3 voltage
   output logic [15:0] u_ch4 // Channel 4 voltage
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {i_l1, i_l2, i_l3, u_ch1, u_ch2, u_ch3, u_ch4} <= '0;
      end else if (load) begin
         {i_l1, i_l2, i_l3} <= {cur1, cur2, cur3};
         {u_ch1, u_ch2, u_ch3} <= {volt, volt, volt};
         // Unused by the stage; a distinct value shows it is ignored
         u_ch4 <= ~volt;
      end
   end
endmodule
`default_nettype wire

// file: vro_pkg.sv
// Shared constants and types for the voltage-restrained overcurrent stage
package vro_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROGRAM_CYCLE_NS = 5000000;
   localparam int CYCLE_CLKS = PROGRAM_CYCLE_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] ILOW_OFS = 8'h04;
   localparam logic [7:0] IHIGH_OFS = 8'h08;
   localparam logic [7:0] ULOW_OFS = 8'h0C;
   localparam logic [7:0] UHIGH_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] PICKUP_OFS = 8'h18;
   localparam logic [7:0] U1_OFS = 8'h1C;
   localparam logic [7:0] RATIO_OFS = 8'h20;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h2C;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h30;

   // Control register fields
   localparam int ALLOW_MODE_BIT = 0;
   localparam int FORCE_EN_BIT = 1;
   localparam int MODE_LSB = 4;
   localparam int FORCE_LSB = 8;

   // Status register fields
   localparam int COND_LSB = 0;
   localparam int PICK_LSB = 4;
   localparam int RESTR_BIT = 8;
   localparam int BLK_BIT = 9;
   localparam int EFF_MODE_LSB = 12;

   // Interrupt bits
   localparam int IRQ_BITS = 4;
   localparam int IRQ_START_ON = 0;
   localparam int IRQ_START_OFF = 1;
   localparam int IRQ_BLK_ON = 2;
   localparam int IRQ_BLK_OFF = 3;

   // Reset values: currents in 0.01 xIn, voltages in 0.01 %Un
   localparam logic [15:0] ILOW_RST = 16'h0014;
   localparam logic [15:0] IHIGH_RST = 16'h0078;
   localparam logic [15:0] ULOW_RST = 16'h07D0;
   localparam logic [15:0] UHIGH_RST = 16'h2710;

   localparam logic [23:0] RESET_RATIO_PCT = 24'h000061;
   localparam logic [23:0] PCT_SCALE = 24'h000064;
   localparam logic [31:0] RATIO_SCALE = 32'h00000064;
   // Approximate 1/3 in 16-bit fixed point
   localparam logic [15:0] THIRD_Q16 = 16'h5556;

   typedef enum logic [2:0] {
      MODE_ON = 3'b000,
      MODE_BLOCKED = 3'b001,
      MODE_TEST = 3'b010,
      MODE_TEST_BLOCKED = 3'b011,
      MODE_OFF = 3'b100
   } vro_mode_type;

   typedef enum logic [1:0] {
      COND_NORMAL = 2'b00,
      COND_START = 2'b01,
      COND_TRIP = 2'b10,
      COND_BLOCKED = 2'b11
   } vro_cond_type;
endpackage

// file: vro_stage.sv
// Voltage-restrained overcurrent stage with AHB-Lite register slave
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - With the high voltage knee above the low one the stage runs restrained.
// - In restrained mode the pick-up level rises as voltage rises between the knees.
// - The steering voltage is the positive sequence estimate from voltage channels 1 to 3; channel 4 is unused.
// - Equal voltage knees give voltage-controlled action, live only below that voltage.
// - Three phase currents and four voltage channels arrive on a 5 ms time base.
// - Each program cycle a current to pick-up ratio is computed per phase.
// - A phase current above the pick-up level is a pick-up condition.
// - A picked phase releases only below 97 percent of the pick-up level.
// - Operating mode on, blocked, test, test-blocked or off, default on, needs allow bit.
// - Forced status normal, start, trip or blocked, default normal, needs enable bit.
// - Mode and forcing settings sit apart from the group-switchable knees.
// - Knee settings may change while running and take effect next program cycle.
// - Current knees in 0.01 xIn steps, defaults 0.2 and 1.2 xIn.
// - Voltage knees in 0.01 %Un steps, defaults 20 and 100 %Un.
// - Blocking is sampled at each cycle start; pick-up while blocked gives blocked.
module vro_stage #(
   parameter int CYCLE_CLKS = vro_pkg::CYCLE_CLKS
) (
   input wire logic hclk, // Clock, 100 MHz
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write
   input wire logic [2:0] hsize, // Size, word only
   input wire logic [31:0] hwdata, // Write data
   input wire logic hready, // Bus ready
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Response, always OKAY
   input wire logic [15:0] i_l1, // Phase 1 current, 0.01 xIn
   input wire logic [15:0] i_l2, // Phase 2 current
   input wire logic [15:0] i_l3, // Phase 3 current
   input wire logic [15:0] u_ch1, // Voltage channel 1, 0.01 %Un
   input wire logic [15:0] u_ch2, // Voltage channel 2
   input wire logic [15:0] u_ch3, // Voltage channel 3
   input wire logic [15:0] u_ch4, // Voltage channel 4
   input wire logic block_in, // Blocking input, asynchronous
   output logic start_out, // Start condition
   output logic trip_out, // Trip condition
   output logic blocked_out, // Blocked condition
   output logic irq // Interrupt, level
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PU = 3'b001,
      ST_WAIT_PU = 3'b010,
      ST_EVAL = 3'b011,
      ST_WAIT_R = 3'b100
   } vro_state_type;

   vro_state_type state_q;
   logic [31:0] tick_cnt_q;
   logic tick_q;
   logic blk_s1_q, blk_s2_q, blk_q;
   logic [15:0] ilow_q, ihigh_q, ulow_q, uhigh_q;
   logic allow_mode_q, force_en_q;
   vro_pkg::vro_mode_type mode_q, eff_mode;
   vro_pkg::vro_cond_type force_q, eff_force, cond_q, cond_d;
   logic [15:0] im_q [3];
   logic [15:0] u1_q, pickup_q;
   logic [15:0] ratio_q [3];
   logic [2:0] picked_q, pick_d;
   logic [1:0] idx_q;
   logic restrained, interp, armed;
   logic [17:0] u_sum;
   logic [33:0] u_prod;
   logic [15:0] di;
   logic div_start, div_busy, div_done;
   logic [31:0] div_num, div_q;
   logic [15:0] div_den;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] rd_data;
   logic [vro_pkg::IRQ_BITS-1:0] irq_st_q, irq_mask_q, irq_ev;
   logic addr_ok;

   assign restrained = (uhigh_q > ulow_q);
   assign interp = restrained && (u1_q > ulow_q) && (u1_q < uhigh_q);
   assign armed = restrained || (u1_q < ulow_q);
   assign di = (ihigh_q >= ilow_q) ? (ihigh_q - ilow_q) : (ilow_q - ihigh_q);
   assign eff_mode = allow_mode_q ? mode_q : vro_pkg::MODE_ON;
   assign eff_force = force_en_q ? force_q : vro_pkg::COND_NORMAL;
   // Balanced magnitude estimate of the positive sequence voltage
   assign u_sum = {2'b00, u_ch1} + {2'b00, u_ch2} + {2'b00, u_ch3};
   assign u_prod = {16'h0000, u_sum} * {18'h00000, vro_pkg::THIRD_Q16};

   // Program cycle divider
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == 32'(CYCLE_CLKS - 1));
         tick_cnt_q <= (tick_cnt_q == 32'(CYCLE_CLKS - 1)) ? 32'h00000000 : tick_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_s1_q <= 1'b0;
         blk_s2_q <= 1'b0;
      end else begin
         blk_s1_q <= block_in;
         blk_s2_q <= blk_s1_q;
      end
   end

   // Inputs latched at the start of each program cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_q <= 1'b0;
         u1_q <= 16'h0000;
         im_q <= '{default: 16'h0000};
      end else if (tick_q && state_q == ST_IDLE) begin
         blk_q <= blk_s2_q;
         u1_q <= u_prod[31:16];
         im_q <= '{i_l1, i_l2, i_l3};
      end
   end

   always_comb begin
      div_start = 1'b0;
      div_num = 32'h00000000;
      div_den = 16'h0000;
      if (state_q == ST_PU && interp) begin
         div_start = 1'b1;
         div_num = {16'h0000, di} * {16'h0000, (u1_q - ulow_q)};
         div_den = uhigh_q - ulow_q;
      end else if (state_q == ST_EVAL || (state_q == ST_WAIT_R && div_done && idx_q != 2'd2)) begin
         div_start = 1'b1;
         div_num = {16'h0000, im_q[(state_q == ST_EVAL) ? 2'd0 : idx_q + 2'd1]} * vro_pkg::RATIO_SCALE;
         div_den = pickup_q;
      end
   end

   vro_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_den),
      .busy(div_busy),
      .done(div_done),
      .quotient(div_q)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         idx_q <= 2'd0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (tick_q) state_q <= ST_PU;
            end
            ST_PU: begin
               state_q <= interp ? ST_WAIT_PU : ST_EVAL;
            end
            ST_WAIT_PU: begin
               if (div_done) state_q <= ST_EVAL;
            end
            ST_EVAL: begin
               idx_q <= 2'd0;
               state_q <= ST_WAIT_R;
            end
            ST_WAIT_R: begin
               if (div_done) begin
                  if (idx_q == 2'd2) state_q <= ST_IDLE;
                  else idx_q <= idx_q + 2'd1;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Pick-up level from the knee characteristic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pickup_q <= vro_pkg::ILOW_RST;
      end else if (state_q == ST_PU && !interp) begin
         pickup_q <= (restrained && u1_q >= uhigh_q) ? ihigh_q : ilow_q;
      end else if (state_q == ST_WAIT_PU && div_done) begin
         pickup_q <= (ihigh_q >= ilow_q) ? ilow_q + div_q[15:0] : ilow_q - div_q[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ratio_q <= '{default: 16'h0000};
      end else if (state_q == ST_WAIT_R && div_done) begin
         ratio_q[idx_q] <= (div_q > 32'h0000FFFF) ? 16'hFFFF : div_q[15:0];
      end
   end

   for (genvar g = 0; g < 3; g++) begin : g_phase
      logic [23:0] im_pct, pu_rel;
      assign im_pct = {8'h00, im_q[g]} * vro_pkg::PCT_SCALE;
      assign pu_rel = {8'h00, pickup_q} * vro_pkg::RESET_RATIO_PCT;
      assign pick_d[g] = armed && (eff_mode != vro_pkg::MODE_OFF) &&
         (picked_q[g] ? (im_pct >= pu_rel) : (im_q[g] > pickup_q));
   end

   always_comb begin
      if (eff_force != vro_pkg::COND_NORMAL) begin
         cond_d = eff_force;
      end else if (|pick_d) begin
         cond_d = (blk_q || eff_mode == vro_pkg::MODE_BLOCKED ||
            eff_mode == vro_pkg::MODE_TEST_BLOCKED) ? vro_pkg::COND_BLOCKED : vro_pkg::COND_START;
      end else begin
         cond_d = vro_pkg::COND_NORMAL;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         picked_q <= 3'b000;
         cond_q <= vro_pkg::COND_NORMAL;
      end else if (state_q == ST_EVAL) begin
         picked_q <= pick_d;
         cond_q <= cond_d;
      end
   end

   assign start_out = (cond_q == vro_pkg::COND_START);
   assign trip_out = (cond_q == vro_pkg::COND_TRIP);
   assign blocked_out = (cond_q == vro_pkg::COND_BLOCKED);

   // Bus slave: zero wait states, write applied in data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'b010);

   always_comb begin
      case (haddr[7:0])
         vro_pkg::CTRL_OFS: rd_data = 32'({force_q, 1'b0, mode_q, 2'b00,
            force_en_q, allow_mode_q});
         vro_pkg::ILOW_OFS: rd_data = {16'h0000, ilow_q};
         vro_pkg::IHIGH_OFS: rd_data = {16'h0000, ihigh_q};
         vro_pkg::ULOW_OFS: rd_data = {16'h0000, ulow_q};
         vro_pkg::UHIGH_OFS: rd_data = {16'h0000, uhigh_q};
         vro_pkg::STATUS_OFS: rd_data = 32'({1'b0, eff_mode, 2'b00, blk_q, restrained,
            1'b0, picked_q, 2'b00, cond_q});
         vro_pkg::PICKUP_OFS: rd_data = {16'h0000, pickup_q};
         vro_pkg::U1_OFS: rd_data = {16'h0000, u1_q};
         vro_pkg::RATIO_OFS: rd_data = {16'h0000, ratio_q[0]};
         vro_pkg::RATIO_OFS + 8'h04: rd_data = {16'h0000, ratio_q[1]};
         vro_pkg::RATIO_OFS + 8'h08: rd_data = {16'h0000, ratio_q[2]};
         vro_pkg::IRQ_STAT_OFS: rd_data = 32'(irq_st_q);
         vro_pkg::IRQ_MASK_OFS: rd_data = 32'(irq_mask_q);
         default: rd_data = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         wr_pend_q <= addr_ok && hwrite;
         if (addr_ok) wr_addr_q <= haddr[7:0];
         if (addr_ok && !hwrite) hrdata <= rd_data;
      end
   end

   // Static settings, outside any setting group
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         allow_mode_q <= 1'b0;
         force_en_q <= 1'b0;
         mode_q <= vro_pkg::MODE_ON;
         force_q <= vro_pkg::COND_NORMAL;
      end else if (wr_pend_q && wr_addr_q == vro_pkg::CTRL_OFS) begin
         allow_mode_q <= hwdata[vro_pkg::ALLOW_MODE_BIT];
         force_en_q <= hwdata[vro_pkg::FORCE_EN_BIT];
         mode_q <= (hwdata[vro_pkg::MODE_LSB +: 3] > 3'b100) ? vro_pkg::MODE_ON :
            vro_pkg::vro_mode_type'(hwdata[vro_pkg::MODE_LSB +: 3]);
         force_q <= vro_pkg::vro_cond_type'(hwdata[vro_pkg::FORCE_LSB +: 2]);
      end
   end

   // Group-switchable knees, applied live
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ilow_q <= vro_pkg::ILOW_RST;
         ihigh_q <= vro_pkg::IHIGH_RST;
         ulow_q <= vro_pkg::ULOW_RST;
         uhigh_q <= vro_pkg::UHIGH_RST;
      end else if (wr_pend_q) begin
         if (wr_addr_q == vro_pkg::ILOW_OFS) ilow_q <= hwdata[15:0];
         if (wr_addr_q == vro_pkg::IHIGH_OFS) ihigh_q <= hwdata[15:0];
         if (wr_addr_q == vro_pkg::ULOW_OFS) ulow_q <= hwdata[15:0];
         if (wr_addr_q == vro_pkg::UHIGH_OFS) uhigh_q <= hwdata[15:0];
      end
   end

   // Sticky events, write one to clear, set wins
   always_comb begin
      irq_ev = '0;
      if (state_q == ST_EVAL) begin
         irq_ev[vro_pkg::IRQ_START_ON] = (cond_d == vro_pkg::COND_START) && !start_out;
         irq_ev[vro_pkg::IRQ_START_OFF] = (cond_d != vro_pkg::COND_START) && start_out;
         irq_ev[vro_pkg::IRQ_BLK_ON] = (cond_d == vro_pkg::COND_BLOCKED) && !blocked_out;
         irq_ev[vro_pkg::IRQ_BLK_OFF] = (cond_d != vro_pkg::COND_BLOCKED) && blocked_out;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_q <= '0;
         irq_mask_q <= '0;
      end else begin
         if (wr_pend_q && wr_addr_q == vro_pkg::IRQ_STAT_OFS) begin
            irq_st_q <= (irq_st_q & ~hwdata[vro_pkg::IRQ_BITS-1:0]) | irq_ev;
         end else begin
            irq_st_q <= irq_st_q | irq_ev;
         end
         if (wr_pend_q && wr_addr_q == vro_pkg::IRQ_MASK_OFS) begin
            irq_mask_q <= hwdata[vro_pkg::IRQ_BITS-1:0];
         end
      end
   end

   assign irq = |(irq_st_q & irq_mask_q);

   low_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && restrained && u1_q <= ulow_q) |-> pickup_q == ilow_q)
      else $error("pickup not at low knee");
   high_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && restrained && u1_q >= uhigh_q) |-> pickup_q == ihigh_q)
      else $error("pickup not at high knee");
   rise_between_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && restrained && ilow_q <= ihigh_q && $stable(ilow_q) &&
      $stable(ihigh_q)) |-> pickup_q >= ilow_q && pickup_q <= ihigh_q)
      else $error("pickup outside knees");
   vc_inhibit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && !restrained && u1_q >= ulow_q) |=> picked_q == 3'b000)
      else $error("controlled mode picked above voltage");
   pick_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && armed && eff_mode != vro_pkg::MODE_OFF && im_q[0] > pickup_q)
      |=> picked_q[0])
      else $error("phase 1 failed to pick up");
   reset_ratio_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && armed && picked_q[1] && eff_mode != vro_pkg::MODE_OFF &&
      {8'h00, im_q[1]} * 24'd100 >= {8'h00, pickup_q} * 24'd97) |=> picked_q[1])
      else $error("phase 2 released above 97 percent");
   block_cond_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && |pick_d && blk_q && !force_en_q) |=> blocked_out && !start_out)
      else $error("blocked pick-up did not give blocked");
   mode_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && eff_mode == vro_pkg::MODE_OFF) |=> picked_q == 3'b000)
      else $error("off mode picked up");
   ratio_seq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL) |=> ##[1:120] (state_q == ST_IDLE))
      else $error("ratios not finished");
   force_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == ST_EVAL && force_en_q && force_q == vro_pkg::COND_TRIP) |=> trip_out)
      else $error("forced trip missing");
endmodule
`default_nettype wire
